// ==== logic/lpc_pkg.sv ====
// shared constants for the low-power calibration and trim register block
package lpc_pkg;

    // register offsets
    localparam logic [7:0] ADDR_TRIG_SRC  = 8'h6b;
    localparam logic [7:0] ADDR_SOFT_TRIG = 8'h6c;
    localparam logic [7:0] ADDR_LP_CTRL   = 8'h6e;
    localparam logic [7:0] ADDR_BG_CTRL   = 8'h70;
    localparam logic [7:0] ADDR_STATUS    = 8'h71;
    localparam logic [7:0] ADDR_GAIN      = 8'h7a;
    localparam logic [7:0] ADDR_REF       = 8'h7c;
    localparam logic [7:0] ADDR_TERM_A    = 8'h7e;
    localparam logic [7:0] ADDR_TERM_B    = 8'h7f;
    localparam logic [7:0] ADDR_TERM_C    = 8'h80;

    // low_power_cal_control field positions
    localparam int IDLE_SEL_MSB   = 7;
    localparam int IDLE_SEL_LSB   = 5;
    localparam int SETTLE_SEL_MSB = 4;
    localparam int SETTLE_SEL_LSB = 3;
    localparam int TRIG_SLEEP_BIT = 1;
    localparam int LOW_POWER_CAL_ENABLE_BIT      = 0;
    // single-bit control registers keep their bit here
    localparam int CTRL_BIT       = 0;
    localparam int REF_FIELD_W    = 4;

    // reset values
    localparam logic [7:0] RST_LP_CTRL   = 8'h88;
    localparam logic       RST_SOFT_TRIG = 1'h1;
    localparam logic       RST_TRIG_SRC  = 1'h0;
    localparam logic       RST_BG_EN     = 1'h0;
    localparam logic [7:0] RST_TRIM      = 8'h00;
    localparam logic [7:0] RD_ZERO       = 8'h00;

    // interval counts, in sampling clock periods (clk)
    localparam int TMR_W = 41;
    typedef logic [TMR_W-1:0] lpc_cnt_t;
    localparam lpc_cnt_t IDLE_CNT_DFLT [8] = '{
        41'd1152, 41'd4194432, 41'd33554560, 41'd268435584,
        41'd2147483776, 41'd17179869312, 41'd137438953600,
        41'd1099511627904};
    localparam lpc_cnt_t SETTLE_CNT_DFLT [4] = '{
        41'd1152, 41'd33554560, 41'd268435584, 41'd2147483776};

    typedef enum logic [1:0] {
        LPC_READY,
        LPC_SLEEP,
        LPC_SETTLE,
        LPC_CAL
    } lpc_state_t;

endpackage

// ==== logic/lpc_timer.sv ====
// down-counting interval timer, restarted by a start pulse
`timescale 1ns/1ps
module lpc_timer #(
    parameter int W = lpc_pkg::TMR_W
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         start,
    input  wire logic [W-1:0] len,
    output logic              done,
    output logic              busy
);
    import lpc_pkg::*;

    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_busy;

    // done is high in the last of len cycles after start
    assign done = busy && (cnt == '0);

    always_comb begin
        next_cnt  = cnt;
        next_busy = busy;
        if (start) begin
            next_cnt  = len - W'(1);
            next_busy = 1'b1;
        end else if (busy) begin
            if (cnt == '0) begin
                next_busy = 1'b0;
            end else begin
                next_cnt = cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt  <= '0;
            busy <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            busy <= next_busy;
        end
    end

endmodule

// ==== logic/lpc_regs.sv ====
// low-power background calibration control and factory trim registers
// What this block does
// - idle select codes 0..7 pick the sleep length in clock periods
// - timed sleep only when low power on and trigger-driven sleep off
// - idle select resets to 4; codes below 4 save little power
// - settle select codes 0..3 pick wake settle wait; resets to 1
// - settle wait applies in both sleep modes while low power is on
// - trigger-driven bit 0: sleep is timed autonomously from idle select
// - trigger-driven bit 1: sleep while trigger high, wake when low
// - low power enable bit 0 resets off, acts only with background cal
// - 8-bit gain adjust trims all cores together
// - 4-bit band-gap adjust holds factory value, readable and writable
// - channel A, B, C termination adjust registers, factory loaded
// - trim registers take post-reset values from the fuse loader
// - trigger comes from software bit or pin per source select
`timescale 1ns/1ps
module lpc_regs #(
    parameter lpc_pkg::lpc_cnt_t IDLE_CNT [8]   = lpc_pkg::IDLE_CNT_DFLT,
    parameter lpc_pkg::lpc_cnt_t SETTLE_CNT [4] = lpc_pkg::SETTLE_CNT_DFLT
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data,
    input  wire logic       fuse_valid,
    input  wire logic [7:0] fuse_gain,
    input  wire logic [3:0] fuse_ref,
    input  wire logic [7:0] fuse_term_a,
    input  wire logic [7:0] fuse_term_b,
    input  wire logic [7:0] fuse_term_c,
    input  wire logic       cal_trigger_pin,
    input  wire logic       cal_done,
    output logic            core_sleep,
    output logic            cal_start,
    output logic            lp_active,
    output logic      [7:0] gain_adjust,
    output logic      [3:0] ref_adjust,
    output logic      [7:0] term_adjust_a,
    output logic      [7:0] term_adjust_b,
    output logic      [7:0] term_adjust_c
);
    import lpc_pkg::*;

    // software-visible registers
    logic [7:0] low_power_cal_control;
    logic       cal_trigger_source_sel;
    logic       software_cal_trigger;
    logic       background_cal_enable;
    logic [7:0] core_gain_adjust;
    logic [7:0] reference_voltage_adjust;
    logic [7:0] termination_adjust_ch_a;
    logic [7:0] termination_adjust_ch_b;
    logic [7:0] termination_adjust_ch_c;
    logic [7:0] next_low_power_cal_control;
    logic       next_cal_trigger_source_sel;
    logic       next_software_cal_trigger;
    logic       next_background_cal_enable;
    logic [7:0] next_core_gain_adjust;
    logic [7:0] next_reference_voltage_adjust;
    logic [7:0] next_termination_adjust_ch_a;
    logic [7:0] next_termination_adjust_ch_b;
    logic [7:0] next_termination_adjust_ch_c;
    logic [7:0] next_rd_data;
    // trigger pin synchroniser and filter
    logic trig_ff1;
    logic trig_ff2;
    logic trig_ff3;
    logic trig_pin_q;
    logic next_trig_pin_q;
    // sequencer
    lpc_state_t state;
    lpc_state_t next_state;
    logic       sleep_mode;
    logic       next_sleep_mode;
    logic       next_core_sleep;
    logic       next_cal_start;
    logic       next_lp_active;
    logic       tmr_start;
    lpc_cnt_t   tmr_len;
    logic       tmr_done;
    logic       tmr_busy;
    logic       lp_enable;
    logic       trig_mode;
    logic       trig_eff;
    logic [2:0] idle_sel;
    logic [1:0] settle_sel;
    assign idle_sel   = low_power_cal_control[IDLE_SEL_MSB:IDLE_SEL_LSB];
    assign settle_sel = low_power_cal_control[SETTLE_SEL_MSB:SETTLE_SEL_LSB];
    assign trig_mode  = low_power_cal_control[TRIG_SLEEP_BIT];
    // low power is only honoured under background calibration
    assign lp_enable  = low_power_cal_control[LOW_POWER_CAL_ENABLE_BIT]
                        && background_cal_enable;
    assign trig_eff   = cal_trigger_source_sel ? trig_pin_q
                                               : software_cal_trigger;
    assign gain_adjust   = core_gain_adjust;
    assign ref_adjust    = reference_voltage_adjust[REF_FIELD_W-1:0];
    assign term_adjust_a = termination_adjust_ch_a;
    assign term_adjust_b = termination_adjust_ch_b;
    assign term_adjust_c = termination_adjust_ch_c;
    // register writes and fuse loading
    always_comb begin
        next_low_power_cal_control    = low_power_cal_control;
        next_cal_trigger_source_sel   = cal_trigger_source_sel;
        next_software_cal_trigger     = software_cal_trigger;
        next_background_cal_enable    = background_cal_enable;
        next_core_gain_adjust         = core_gain_adjust;
        next_reference_voltage_adjust = reference_voltage_adjust;
        next_termination_adjust_ch_a  = termination_adjust_ch_a;
        next_termination_adjust_ch_b  = termination_adjust_ch_b;
        next_termination_adjust_ch_c  = termination_adjust_ch_c;
        if (wr_en) begin
            case (addr)
                ADDR_LP_CTRL:   next_low_power_cal_control = wr_data;
                ADDR_TRIG_SRC: next_cal_trigger_source_sel = wr_data[CTRL_BIT];
                ADDR_SOFT_TRIG: next_software_cal_trigger = wr_data[CTRL_BIT];
                ADDR_BG_CTRL: next_background_cal_enable = wr_data[CTRL_BIT];
                ADDR_GAIN:      next_core_gain_adjust = wr_data;
                ADDR_REF: next_reference_voltage_adjust = wr_data;
                ADDR_TERM_A: next_termination_adjust_ch_a = wr_data;
                ADDR_TERM_B: next_termination_adjust_ch_b = wr_data;
                ADDR_TERM_C: next_termination_adjust_ch_c = wr_data;
                default: ;
            endcase
        end
        // factory values arrive after reset and win over a same-cycle write
        if (fuse_valid) begin
            next_core_gain_adjust         = fuse_gain;
            next_reference_voltage_adjust = {4'h0, fuse_ref};
            next_termination_adjust_ch_a  = fuse_term_a;
            next_termination_adjust_ch_b  = fuse_term_b;
            next_termination_adjust_ch_c  = fuse_term_c;
        end
    end
    // read data stands in the cycle after the read strobe
    always_comb begin
        next_rd_data = RD_ZERO;
        if (rd_en) begin
            case (addr)
                ADDR_LP_CTRL:   next_rd_data = low_power_cal_control;
                ADDR_TRIG_SRC:  next_rd_data = {7'h0, cal_trigger_source_sel};
                ADDR_SOFT_TRIG: next_rd_data = {7'h0, software_cal_trigger};
                ADDR_BG_CTRL:   next_rd_data = {7'h0, background_cal_enable};
                ADDR_STATUS:
                    next_rd_data = {3'h0, tmr_busy, trig_eff, lp_active,
                                    state};
                ADDR_GAIN:      next_rd_data = core_gain_adjust;
                ADDR_REF:       next_rd_data = reference_voltage_adjust;
                ADDR_TERM_A:    next_rd_data = termination_adjust_ch_a;
                ADDR_TERM_B:    next_rd_data = termination_adjust_ch_b;
                ADDR_TERM_C:    next_rd_data = termination_adjust_ch_c;
                default:        next_rd_data = RD_ZERO;
            endcase
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_power_cal_control    <= RST_LP_CTRL;
            cal_trigger_source_sel   <= RST_TRIG_SRC;
            software_cal_trigger     <= RST_SOFT_TRIG;
            background_cal_enable    <= RST_BG_EN;
            core_gain_adjust         <= RST_TRIM;
            reference_voltage_adjust <= RST_TRIM;
            termination_adjust_ch_a  <= RST_TRIM;
            termination_adjust_ch_b  <= RST_TRIM;
            termination_adjust_ch_c  <= RST_TRIM;
            rd_data                  <= RD_ZERO;
        end else begin
            low_power_cal_control    <= next_low_power_cal_control;
            cal_trigger_source_sel   <= next_cal_trigger_source_sel;
            software_cal_trigger     <= next_software_cal_trigger;
            background_cal_enable    <= next_background_cal_enable;
            core_gain_adjust         <= next_core_gain_adjust;
            reference_voltage_adjust <= next_reference_voltage_adjust;
            termination_adjust_ch_a  <= next_termination_adjust_ch_a;
            termination_adjust_ch_b  <= next_termination_adjust_ch_b;
            termination_adjust_ch_c  <= next_termination_adjust_ch_c;
            rd_data                  <= next_rd_data;
        end
    end
    // pin level is accepted only once the last two stages agree
    always_comb begin
        next_trig_pin_q = trig_pin_q;
        if (trig_ff2 == trig_ff3) begin
            next_trig_pin_q = trig_ff3;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_ff1   <= 1'b0;
            trig_ff2   <= 1'b0;
            trig_ff3   <= 1'b0;
            trig_pin_q <= 1'b0;
        end else begin
            trig_ff1   <= cal_trigger_pin;
            trig_ff2   <= trig_ff1;
            trig_ff3   <= trig_ff2;
            trig_pin_q <= next_trig_pin_q;
        end
    end
    // sleep / settle / calibrate sequencer
    always_comb begin
        next_state      = state;
        next_sleep_mode = sleep_mode;
        next_cal_start  = 1'b0;
        tmr_start       = 1'b0;
        tmr_len         = IDLE_CNT[idle_sel];
        case (state)
            LPC_READY: begin
                if (lp_enable) begin
                    if (!trig_mode) begin
                        next_state      = LPC_SLEEP;
                        next_sleep_mode = 1'b0;
                        tmr_start       = 1'b1;
                    end else if (trig_eff) begin
                        next_state      = LPC_SLEEP;
                        next_sleep_mode = 1'b1;
                    end
                end
            end
            LPC_SLEEP: begin
                // a mode change mid-sleep drops back and re-enters cleanly
                if (!lp_enable || trig_mode != sleep_mode) begin
                    next_state = LPC_READY;
                end else if (sleep_mode ? !trig_eff : tmr_done) begin
                    next_state = LPC_SETTLE;
                    tmr_len    = SETTLE_CNT[settle_sel];
                    tmr_start  = 1'b1;
                end
            end
            LPC_SETTLE: begin
                if (!lp_enable) begin
                    next_state = LPC_READY;
                end else if (tmr_done) begin
                    next_state     = LPC_CAL;
                    next_cal_start = 1'b1;
                end
            end
            LPC_CAL: begin
                if (!lp_enable || cal_done) begin
                    next_state = LPC_READY;
                end
            end
            default: next_state = LPC_READY;
        endcase
        next_core_sleep = (next_state == LPC_SLEEP);
        next_lp_active  = lp_enable;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state      <= LPC_READY;
            sleep_mode <= 1'b0;
            core_sleep <= 1'b0;
            cal_start  <= 1'b0;
            lp_active  <= 1'b0;
        end else begin
            state      <= next_state;
            sleep_mode <= next_sleep_mode;
            core_sleep <= next_core_sleep;
            cal_start  <= next_cal_start;
            lp_active  <= next_lp_active;
        end
    end
    lpc_timer #(.W (TMR_W)) u_timer (
        .clk   (clk),
        .rst   (rst),
        .start (tmr_start),
        .len   (tmr_len),
        .done  (tmr_done),
        .busy  (tmr_busy)
    );
    // checking helpers: cycles spent in the current state and its length
    lpc_cnt_t dwell;
    lpc_cnt_t dwell_len;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dwell     <= '0;
            dwell_len <= '0;
        end else begin
            dwell <= (next_state != state) ? '0 : dwell + TMR_W'(1);
            if (tmr_start) begin
                dwell_len <= tmr_len;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence settle_done_s;
        state == LPC_SETTLE && next_state == LPC_CAL;
    endsequence
    sequence cal_pulse_s;
        cal_start ##1 !cal_start;
    endsequence
    timed_sleep_len_a: assert property (
        (state == LPC_SLEEP && next_state == LPC_SETTLE && !sleep_mode)
        |-> dwell == dwell_len - TMR_W'(1))
        else $error("timed sleep length differs from idle select");
    timed_only_a: assert property (
        (state == LPC_SLEEP && !sleep_mode && next_state == LPC_SETTLE)
        |-> lp_enable && !trig_mode && tmr_done)
        else $error("timed sleep used outside timed mode");
    settle_len_a: assert property (
        (settle_done_s and (dwell == dwell_len - TMR_W'(1)))
        or !(state == LPC_SETTLE && next_state == LPC_CAL))
        else $error("settle wait differs from settle select");
    settle_start_a: assert property (
        settle_done_s |=> cal_pulse_s)
        else $error("calibration start not a single pulse after settle");
    trig_sleep_a: assert property (
        (state == LPC_READY && lp_enable && trig_mode && trig_eff)
        |=> core_sleep && state == LPC_SLEEP)
        else $error("core not put to sleep while trigger high");
    trig_wake_a: assert property (
        (state == LPC_SLEEP && sleep_mode && trig_mode && lp_enable
         && !trig_eff) |=> !core_sleep ##0 state == LPC_SETTLE)
        else $error("core not woken when trigger went low");
    no_sleep_off_a: assert property (
        !lp_enable |=> !core_sleep ##1 !cal_start)
        else $error("sleep or calibrate while low power disabled");
    fuse_load_a: assert property (
        fuse_valid |=> gain_adjust == $past(fuse_gain)
        && term_adjust_c == $past(fuse_term_c))
        else $error("fuse values not loaded into trims");
    ref_upper_a: assert property (
        fuse_valid |=> reference_voltage_adjust[7:4] == 4'h0
        && ref_adjust == $past(fuse_ref))
        else $error("band-gap trim not loaded with upper bits clear");

endmodule

// ==== sim/lpc_tb.sv ====
// self-checking testbench for the low-power calibration and trim registers
`timescale 1ns/1ps
module testbench;
    import lpc_pkg::*;

    localparam lpc_cnt_t IDLE [8]   = '{41'd8, 41'd9, 41'd10, 41'd11,
                                        41'd12, 41'd13, 41'd14, 41'd15};
    localparam lpc_cnt_t SETTLE [4] = '{41'd5, 41'd6, 41'd7, 41'd8};

    logic       clk;
    logic       rst;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] rd_data;
    logic       fuse_valid;
    logic [7:0] fuse_gain;
    logic [3:0] fuse_ref;
    logic [7:0] fuse_term_a;
    logic [7:0] fuse_term_b;
    logic [7:0] fuse_term_c;
    logic       cal_trigger_pin;
    logic       cal_done;
    logic       core_sleep;
    logic       cal_start;
    logic       lp_active;
    logic [7:0] gain_adjust;
    logic [3:0] ref_adjust;
    logic [7:0] term_adjust_a;
    logic [7:0] term_adjust_b;
    logic [7:0] term_adjust_c;
    int         failures;
    int         n_tests;

    lpc_regs #(.IDLE_CNT(IDLE), .SETTLE_CNT(SETTLE)) DUT (
        .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .fuse_valid(fuse_valid), .fuse_gain(fuse_gain),
        .fuse_ref(fuse_ref), .fuse_term_a(fuse_term_a),
        .fuse_term_b(fuse_term_b), .fuse_term_c(fuse_term_c),
        .cal_trigger_pin(cal_trigger_pin), .cal_done(cal_done),
        .core_sleep(core_sleep), .cal_start(cal_start),
        .lp_active(lp_active), .gain_adjust(gain_adjust),
        .ref_adjust(ref_adjust), .term_adjust_a(term_adjust_a),
        .term_adjust_b(term_adjust_b), .term_adjust_c(term_adjust_c));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [40:0] seen,
                       input logic [40:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en   <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk("read data", d, exp);
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return core_sleep;
            1: return cal_start;
            default: return lp_active;
        endcase
    endfunction

    // counts edges until the chosen output shows v; a spent bound ends the run
    task automatic wait_sig(input int w, input logic v, input int lim,
                            output int n);
        n = 0;
        forever begin
            @(posedge clk);
            #1;
            n++;
            if (pick(w) === v) break;
            if (n >= lim) begin
                failures++;
                $display("MISMATCH wait on output %0d expected %0b", w, v);
                report_and_stop();
            end
        end
    endtask

    task automatic finish_cal();
        @(posedge clk);
        cal_done <= 1'b1;
        @(posedge clk);
        cal_done <= 1'b0;
    endtask

    task automatic test_reset();
        rd_chk(ADDR_LP_CTRL, 8'h88);
        rd_chk(ADDR_SOFT_TRIG, 8'h01);
        rd_chk(ADDR_TRIG_SRC, 8'h00);
        rd_chk(ADDR_GAIN, 8'h00);
        rd_chk(8'h55, 8'h00);
        chk("core_sleep", core_sleep, 1'b0);
        chk("lp_active", lp_active, 1'b0);
        $display("test reset done");
    endtask

    task automatic test_trims();
        logic [7:0] a [5] = '{ADDR_GAIN, ADDR_REF, ADDR_TERM_A,
                              ADDR_TERM_B, ADDR_TERM_C};
        @(posedge clk);
        fuse_valid  <= 1'b1;
        fuse_gain   <= 8'ha5;
        fuse_ref    <= 4'h9;
        fuse_term_a <= 8'h3c;
        fuse_term_b <= 8'hc3;
        fuse_term_c <= 8'h5e;
        @(posedge clk);
        fuse_valid  <= 1'b0;
        #1;
        chk("gain", gain_adjust, 8'ha5);
        chk("ref", ref_adjust, 4'h9);
        chk("term c", term_adjust_c, 8'h5e);
        rd_chk(ADDR_REF, 8'h09);
        rd_chk(ADDR_TERM_A, 8'h3c);
        rd_chk(ADDR_TERM_B, 8'hc3);
        for (int i = 0; i < 5; i++) begin
            wr(a[i], 8'h01 + 8'(i));
            rd_chk(a[i], 8'h01 + 8'(i));
        end
        chk("gain", gain_adjust, 8'h01);
        chk("ref", ref_adjust, 4'h2);
        chk("term a", term_adjust_a, 8'h03);
        chk("term b", term_adjust_b, 8'h04);
        $display("test trims done");
    endtask

    task automatic test_enable_gate();
        int n;
        wr(ADDR_LP_CTRL, 8'h09);
        repeat (4) @(posedge clk);
        #1;
        chk("lp_active", lp_active, 1'b0);
        chk("core_sleep", core_sleep, 1'b0);
        wr(ADDR_BG_CTRL, 8'h01);
        wait_sig(2, 1'b1, 3, n);
        wait_sig(0, 1'b1, 3, n);
        wr(ADDR_BG_CTRL, 8'h00);
        wait_sig(0, 1'b0, 3, n);
        chk("lp_active", lp_active, 1'b0);
        $display("test enable gate done");
    endtask

    task automatic test_timed();
        int n;
        wr(ADDR_BG_CTRL, 8'h01);
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_LP_CTRL, 8'h00);
            wr(ADDR_LP_CTRL, {3'(c), 2'(c % 3 + 1), 3'b001});
            wait_sig(0, 1'b1, 5, n);
            wait_sig(0, 1'b0, 40, n);
            chk("idle length", 41'(n), IDLE[c]);
            wait_sig(1, 1'b1, 40, n);
            chk("settle length", 41'(n), SETTLE[c % 3 + 1]);
            @(posedge clk);
            #1;
            chk("cal_start pulse", cal_start, 1'b0);
            finish_cal();
            wait_sig(0, 1'b1, 3, n);
        end
        wr(ADDR_LP_CTRL, 8'h00);
        $display("test timed done");
    endtask

    task automatic test_trigger();
        int n;
        wr(ADDR_LP_CTRL, 8'h0b);
        wait_sig(0, 1'b1, 5, n);
        repeat (30) @(posedge clk);
        #1;
        chk("sleep held", core_sleep, 1'b1);
        rd_chk(ADDR_STATUS, 8'h0d);
        wr(ADDR_SOFT_TRIG, 8'h00);
        wait_sig(0, 1'b0, 5, n);
        wait_sig(1, 1'b1, 20, n);
        chk("settle length", 41'(n), SETTLE[1]);
        finish_cal();
        wr(ADDR_TRIG_SRC, 8'h01);
        wr(ADDR_SOFT_TRIG, 8'h01);
        repeat (10) @(posedge clk);
        #1;
        chk("pin low", core_sleep, 1'b0);
        cal_trigger_pin <= 1'b1;
        wait_sig(0, 1'b1, 10, n);
        cal_trigger_pin <= 1'b0;
        wait_sig(0, 1'b0, 10, n);
        wait_sig(1, 1'b1, 20, n);
        chk("settle length", 41'(n), SETTLE[1]);
        finish_cal();
        $display("test trigger done");
    endtask

    initial begin
        failures        = 0;
        n_tests         = 0;
        rst             = 1'b1;
        addr            = 8'h00;
        wr_data         = 8'h00;
        wr_en           = 1'b0;
        rd_en           = 1'b0;
        fuse_valid      = 1'b0;
        fuse_gain       = 8'h00;
        fuse_ref        = 4'h0;
        fuse_term_a     = 8'h00;
        fuse_term_b     = 8'h00;
        fuse_term_c     = 8'h00;
        cal_trigger_pin = 1'b0;
        cal_done        = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_trims();
        test_enable_gate();
        test_timed();
        test_trigger();
        report_and_stop();
    end
endmodule
